/* File: include/hmr_pkg.sv */
// package for the health monitor and recovery block: command codes,
// flag positions, reset values and cycle counts at a 250 MHz sys_clk.
// Operation
// - supply_range_ok bit 3 follows supply window
// - phase one waits for excitation_locked
// - fixed delay then automatic filter initialisation
// - internal reset held at least 50 us
// - after start-up rate reads return samples
// - before start-up rate reads return error code
// - filter init command: nonzero holds, zero releases
// - filter init before lock gives recoverable error
// - filter init only with guard open; relock
// - seven monitors, flag low means error
// - low flag pulses stretched to 1.5-2 ms
// - bit 7 low on converter overflow, recoverable
// - bit 6 low on arithmetic fault, fatal
// - bit 5 low on fuse parity fault, fatal
// - bit 4 low in analog test, no substitution
// - bit 2 detection fault, never latched
// - bit 1 excitation lock, recoverable; bit 0 one
// - after start-up flag errors latch substitution, hold
// - fatal error resumes after guard relock
// - no flag error latching while guard open
// - three ordered unlock steps; lock closes guard
// - reenable command 0xAA answers 0x80
// - error code byte is 0x80
// - flag read command 0xB4 returns flags
// assumes a single clock of 250 MHz; link timing lives on sclk.
package hmr_pkg;
    localparam int unsigned CLK_KHZ = 250000;
    // times as printed
    localparam int unsigned RESET_HOLD_US = 50;
    localparam int unsigned STRETCH_US = 1500;
    localparam int unsigned INIT2_MS = 1000;
    // derived cycle counts
    localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_US * CLK_KHZ / 1000;
    localparam int unsigned STRETCH_CYC = STRETCH_US * CLK_KHZ / 1000;
    localparam int unsigned INIT2_CYC = INIT2_MS * CLK_KHZ;

    // command bytes
    localparam logic [7:0] CMD_RATE_HIGH = 8'h80;
    localparam logic [7:0] CMD_RATE_LOW = 8'h8F;
    localparam logic [7:0] CMD_FLAG_READ = 8'hB4;
    localparam logic [7:0] CMD_HPF_INIT = 8'hC4;
    localparam logic [7:0] CMD_UNLOCK1 = 8'h4E;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h63;
    localparam logic [7:0] CMD_UNLOCK3 = 8'h12;
    localparam logic [7:0] CMD_LOCK = 8'h55;
    localparam logic [7:0] CMD_REENABLE = 8'hAA;
    localparam logic [7:0] ADDR_UNLOCK1 = 8'hD7;
    localparam logic [7:0] ADDR_UNLOCK2 = 8'h50;
    localparam logic [7:0] ADDR_UNLOCK3 = 8'hA8;

    // responses
    localparam logic [7:0] ERROR_CODE = 8'h80;
    localparam logic [5:0] LOW_PATTERN = 6'h15;
    localparam logic [7:0] RESP_RESET = 8'h80;

    // flag positions in health_flags
    localparam int unsigned FLAG_CONV = 7;
    localparam int unsigned FLAG_ARITH = 6;
    localparam int unsigned FLAG_FUSE = 5;
    localparam int unsigned FLAG_ATEST = 4;
    localparam int unsigned FLAG_SUPPLY = 3;
    localparam int unsigned FLAG_DETECT = 2;
    localparam int unsigned FLAG_EXC = 1;
    localparam logic [7:0] FLAGS_RESET = 8'hFF;
    localparam logic [7:0] FLAGS_RECOV = 8'h82;
    localparam logic [7:0] FLAGS_FATAL = 8'h68;

    // frame lengths in link clock bits
    localparam logic [4:0] BITS_CMD = 5'h08;
    localparam logic [4:0] BITS_ADDR = 5'h10;

    typedef enum logic [1:0] {
        HMR_PHASE1 = 2'b00,
        HMR_PHASE2 = 2'b01,
        HMR_RUN = 2'b10
    } hmr_start_t;

    // one received frame, captured after the chip select rises
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] addr;
        logic has_addr;
    } hmr_frame_t;

    // raw monitor inputs, 1 means healthy
    typedef struct packed {
        logic conv_ok;
        logic arith_ok;
        logic fuse_ok;
        logic atest_off;
        logic supply_ok;
        logic detect_ok;
        logic excitation_locked;
    } hmr_mon_t;
endpackage

/* File: rtl/hmr_core.sv */
// health monitor, start-up sequencer and command guard of the rate sensor.
// assumes monitor inputs are asynchronous levels, rate_sample comes from the
// filter on sys_clk, and the serial link runs on its own sclk with load high
// between frames.
`timescale 1ns/100ps
`default_nettype none
module hmr_core #(
    parameter int unsigned RESET_HOLD = hmr_pkg::RESET_HOLD_CYC,
    parameter int unsigned STRETCH = hmr_pkg::STRETCH_CYC,
    parameter int unsigned INIT2 = hmr_pkg::INIT2_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // serial link
    input wire logic sclk,
    input wire logic load,
    input wire logic mosi,
    output logic miso_o,
    output logic miso_oe_n,
    // monitors
    input wire hmr_pkg::hmr_mon_t mon_i,
    // signal path
    input wire logic [9:0] rate_sample,
    output logic hpf_init_hold,
    output logic hpf_auto_init,
    output logic proc_hold,
    // status
    output logic [7:0] health_flags,
    output logic startup_done
);
    import hmr_pkg::*;

    // link domain: command shift and response shift
    logic [15:0] rx_q;
    logic [4:0] rx_cnt_q;
    logic [2:0] tx_cnt_q;
    logic [7:0] resp_q;

    always_ff @(posedge sclk) begin
        rx_q <= {rx_q[14:0], mosi};
    end

    // chip select clears the bit count so a short frame is never mistaken
    always_ff @(posedge sclk or posedge load) begin
        if (load) begin
            rx_cnt_q <= 5'h00;
        end else if (rx_cnt_q != BITS_ADDR) begin
            rx_cnt_q <= rx_cnt_q + 5'h01;
        end
    end

    always_ff @(negedge sclk or posedge load) begin
        if (load) begin
            tx_cnt_q <= 3'h0;
        end else begin
            tx_cnt_q <= tx_cnt_q + 3'h1;
        end
    end

    // the chip select clears rx_cnt_q at once, so the length of the frame
    // just ended is kept here for the sys_clk side to read
    logic [4:0] rx_len_q;

    always_ff @(posedge sclk) begin
        if (rx_cnt_q == BITS_ADDR) begin
            rx_len_q <= BITS_ADDR;
        end else begin
            rx_len_q <= rx_cnt_q + 5'h01;
        end
    end

    // resp_q only changes shortly after load rises, so it is quiet for the
    // whole frame and can be read from the link domain
    assign miso_o = resp_q[3'h7 - tx_cnt_q];
    assign miso_oe_n = load;

    // sys domain: internal reset stretcher
    logic [31:0] rst_cnt_q;
    logic int_rst;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rst_cnt_q <= 32'h0000_0000;
        end else if (rst_cnt_q < RESET_HOLD) begin
            rst_cnt_q <= rst_cnt_q + 32'h0000_0001;
        end
    end
    assign int_rst = (rst_cnt_q < RESET_HOLD);

    // synchronisers for monitors and chip select
    hmr_mon_t mon_s1_q;
    hmr_mon_t mon_s2_q;
    logic load_s1_q;
    logic load_s2_q;
    logic load_s3_q;
    logic frame_end;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mon_s1_q <= hmr_mon_t'(7'h7F);
            mon_s2_q <= hmr_mon_t'(7'h7F);
            load_s1_q <= 1'b1;
            load_s2_q <= 1'b1;
            load_s3_q <= 1'b1;
        end else begin
            mon_s1_q <= mon_i;
            mon_s2_q <= mon_s1_q;
            load_s1_q <= load;
            load_s2_q <= load_s1_q;
            load_s3_q <= load_s2_q;
        end
    end
    assign frame_end = load_s2_q & ~load_s3_q;

    // flag stretching: each bit 1..7 holds a low level for STRETCH cycles
    logic [7:0] raw_flags;
    logic [7:0] flags_q;

    always_comb begin
        raw_flags = 8'h01;
        raw_flags[FLAG_CONV] = mon_s2_q.conv_ok;
        raw_flags[FLAG_ARITH] = mon_s2_q.arith_ok;
        raw_flags[FLAG_FUSE] = mon_s2_q.fuse_ok;
        raw_flags[FLAG_ATEST] = mon_s2_q.atest_off;
        raw_flags[FLAG_SUPPLY] = mon_s2_q.supply_ok;
        raw_flags[FLAG_DETECT] = mon_s2_q.detect_ok;
        raw_flags[FLAG_EXC] = mon_s2_q.excitation_locked;
    end

    assign flags_q[0] = 1'b1;

    genvar gi;
    generate
        for (gi = 1; gi < 8; gi++) begin : g_stretch
            logic [31:0] hold_q;
            logic flag_bit_q;
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    hold_q <= 32'h0000_0000;
                    flag_bit_q <= 1'b1;
                end else if (!raw_flags[gi]) begin
                    hold_q <= STRETCH;
                    flag_bit_q <= 1'b0;
                end else if (hold_q != 32'h0000_0000) begin
                    hold_q <= hold_q - 32'h0000_0001;
                    flag_bit_q <= 1'b0;
                end else begin
                    flag_bit_q <= 1'b1;
                end
            end
            assign flags_q[gi] = flag_bit_q;
        end
    endgenerate

    assign health_flags = flags_q;

    // frame decode
    hmr_frame_t frame;

    function automatic logic is_cmd(input hmr_frame_t f, input logic [7:0] c);
        return f.cmd == c;
    endfunction

    function automatic logic is_step(input hmr_frame_t f, input logic [7:0] c,
                                     input logic [7:0] a);
        return (f.cmd == c) && f.has_addr && (f.addr == a);
    endfunction

    // sclk is still once the synchronised chip select has risen, so the
    // frame words are quiet here; one capture moves them into sys_clk
    hmr_frame_t frame_q;
    logic exec_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            frame_q <= '0;
        end else if (frame_end) begin
            frame_q.cmd <= rx_q[7:0];
            frame_q.has_addr <= (rx_len_q == BITS_ADDR);
            frame_q.addr <= (rx_len_q == BITS_ADDR) ? rx_q[15:8] : 8'h00;
        end
    end

    // a frame shorter than one byte is ignored entirely
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            exec_q <= 1'b0;
        end else begin
            exec_q <= frame_end && (rx_len_q >= BITS_CMD);
        end
    end

    logic exec;
    assign frame = frame_q;
    assign exec = exec_q;

    logic known_cmd;
    always_comb begin
        known_cmd = is_cmd(frame, CMD_RATE_HIGH) || is_cmd(frame, CMD_RATE_LOW)
            || is_cmd(frame, CMD_FLAG_READ) || is_cmd(frame, CMD_HPF_INIT)
            || is_cmd(frame, CMD_UNLOCK1) || is_cmd(frame, CMD_UNLOCK2)
            || is_cmd(frame, CMD_UNLOCK3) || is_cmd(frame, CMD_LOCK)
            || is_cmd(frame, CMD_REENABLE);
    end

    // command guard: ordered unlock, single lock command closes it
    logic [1:0] unlock_step_q;
    logic guard_open_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            unlock_step_q <= 2'h0;
            guard_open_q <= 1'b0;
        end else if (int_rst) begin
            unlock_step_q <= 2'h0;
            guard_open_q <= 1'b0;
        end else if (exec) begin
            // any other frame between steps restarts the sequence
            unlock_step_q <= 2'h0;
            if (is_step(frame, CMD_UNLOCK1, ADDR_UNLOCK1)) begin
                unlock_step_q <= 2'h1;
            end else if (unlock_step_q == 2'h1
                         && is_step(frame, CMD_UNLOCK2, ADDR_UNLOCK2)) begin
                unlock_step_q <= 2'h2;
            end else if (unlock_step_q == 2'h2
                         && is_step(frame, CMD_UNLOCK3, ADDR_UNLOCK3)) begin
                guard_open_q <= 1'b1;
            end
            if (is_cmd(frame, CMD_LOCK)) begin
                guard_open_q <= 1'b0;
            end
        end
    end

    logic hpf_cmd;
    logic reenable_cmd;
    assign hpf_cmd = exec && guard_open_q && is_cmd(frame, CMD_HPF_INIT);
    assign reenable_cmd = exec && guard_open_q && is_cmd(frame, CMD_REENABLE);

    // start-up sequencer
    hmr_start_t start_q;
    logic [31:0] init2_cnt_q;
    logic auto_init_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            start_q <= HMR_PHASE1;
            init2_cnt_q <= 32'h0000_0000;
            auto_init_q <= 1'b0;
        end else if (int_rst) begin
            start_q <= HMR_PHASE1;
            init2_cnt_q <= 32'h0000_0000;
            auto_init_q <= 1'b0;
        end else begin
            auto_init_q <= 1'b0;
            case (start_q)
                HMR_PHASE1: begin
                    if (mon_s2_q.excitation_locked) begin
                        start_q <= HMR_PHASE2;
                    end
                end
                HMR_PHASE2: begin
                    if (init2_cnt_q >= INIT2 - 1) begin
                        start_q <= HMR_RUN;
                        auto_init_q <= 1'b1;
                    end else begin
                        init2_cnt_q <= init2_cnt_q + 32'h0000_0001;
                    end
                end
                HMR_RUN: begin
                    start_q <= HMR_RUN;
                end
                default: begin
                    start_q <= HMR_PHASE1;
                end
            endcase
        end
    end

    assign startup_done = (start_q == HMR_RUN);
    assign hpf_auto_init = auto_init_q;

    // manual filter initialisation hold
    logic hpf_hold_q;
    logic exc_seen_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hpf_hold_q <= 1'b0;
            exc_seen_q <= 1'b0;
        end else if (int_rst) begin
            hpf_hold_q <= 1'b0;
            exc_seen_q <= 1'b0;
        end else begin
            if (mon_s2_q.excitation_locked) begin
                exc_seen_q <= 1'b1;
            end
            if (hpf_cmd) begin
                hpf_hold_q <= (frame.addr != 8'h00);
            end
        end
    end
    assign hpf_init_hold = hpf_hold_q;

    // error latches; set wins over reenable, but no flag error latches in the reenable cycle as the guard is open
    logic rec_latch_q;
    logic fatal_latch_q;
    logic rec_set;
    logic fatal_set;
    logic early_hpf;

    assign early_hpf = hpf_cmd && !exc_seen_q;
    assign rec_set = startup_done && !guard_open_q
        && ((flags_q & FLAGS_RECOV) != FLAGS_RECOV);
    assign fatal_set = startup_done && !guard_open_q
        && ((flags_q & FLAGS_FATAL) != FLAGS_FATAL);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rec_latch_q <= 1'b0;
        end else if (int_rst) begin
            rec_latch_q <= 1'b0;
        end else if (rec_set || early_hpf) begin
            rec_latch_q <= 1'b1;
        end else if (reenable_cmd) begin
            rec_latch_q <= 1'b0;
        end
    end

    // fatal latch is not touched by reenable, so it shows again on relock
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fatal_latch_q <= 1'b0;
        end else if (int_rst) begin
            fatal_latch_q <= 1'b0;
        end else if (fatal_set) begin
            fatal_latch_q <= 1'b1;
        end
    end

    // while the guard is open the latches are masked, not cleared
    logic masked;
    assign masked = guard_open_q ? 1'b0 : (rec_latch_q | fatal_latch_q);
    assign proc_hold = masked;

    logic substitute;
    // analog test flag never forces the error code
    assign substitute = !startup_done
        || masked
        || !flags_q[FLAG_DETECT];

    // response register, shifted out during the next frame
    logic [1:0] low_bits_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            resp_q <= RESP_RESET;
            low_bits_q <= 2'h0;
        end else if (int_rst) begin
            resp_q <= RESP_RESET;
            low_bits_q <= 2'h0;
        end else if (exec) begin
            resp_q <= ERROR_CODE;
            if (!known_cmd) begin
                resp_q <= ERROR_CODE;
            end else if (is_cmd(frame, CMD_RATE_HIGH)) begin
                low_bits_q <= rate_sample[1:0];
                resp_q <= substitute ? ERROR_CODE : rate_sample[9:2];
            end else if (is_cmd(frame, CMD_RATE_LOW)) begin
                resp_q <= substitute ? ERROR_CODE : {LOW_PATTERN, low_bits_q};
            end else if (is_cmd(frame, CMD_FLAG_READ)) begin
                resp_q <= flags_q;
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/hmr_core_chk.sv */
// port assertions for the health monitor core, sys_clk domain only
// assumes monitor inputs change on sys_clk edges in simulation
`timescale 1ns/100ps
`default_nettype none
module hmr_core_chk #(
    parameter int unsigned STRETCH = 20,
    parameter int unsigned INIT2 = 50
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // watched ports
    input wire hmr_pkg::hmr_mon_t mon_i,
    input wire logic [7:0] health_flags,
    input wire logic hpf_auto_init,
    input wire logic hpf_init_hold,
    input wire logic proc_hold,
    input wire logic startup_done
);
    import hmr_pkg::*;
    logic [31:0] low_q;
    logic [31:0] exc_q;
    logic [31:0] sup_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // run lengths are wide so they never wrap within one run
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            low_q <= '0;
            exc_q <= '0;
            sup_q <= '0;
        end else begin
            low_q <= health_flags[7] ? '0 : low_q + 32'h0000_0001;
            exc_q <= mon_i.excitation_locked ? exc_q + 32'h0000_0001 : '0;
            sup_q <= mon_i.supply_ok ? sup_q + 32'h0000_0001 : '0;
        end
    end
    a_bit0_set: assert property (health_flags[0])
        else $error("unused flag bit low");
    a_conv_low: assert property (!mon_i.conv_ok |-> ##[1:4] !health_flags[7])
        else $error("converter fault not flagged");
    a_arith_low: assert property (!mon_i.arith_ok |-> ##[1:4] !health_flags[6])
        else $error("arithmetic fault not flagged");
    a_fuse_low: assert property (!mon_i.fuse_ok |-> ##[1:4] !health_flags[5])
        else $error("parity fault not flagged");
    a_supply_low: assert property (!mon_i.supply_ok |-> ##[1:4] !health_flags[3])
        else $error("supply fault not flagged");
    a_detect_low: assert property (!mon_i.detect_ok |-> ##[1:4] !health_flags[2])
        else $error("detect fault not flagged");
    a_supply_high: assert property (sup_q > STRETCH + 8 |-> health_flags[3])
        else $error("supply flag low with supply good");
    a_stretch_min: assert property ($rose(health_flags[7]) |-> low_q >= STRETCH)
        else $error("fault pulse too short");
    a_auto_pulse: assert property (hpf_auto_init |=> !hpf_auto_init && startup_done)
        else $error("automatic init pulse wrong");
    a_start_wait: assert property ($rose(startup_done) |-> exc_q >= INIT2)
        else $error("start-up ended early");
    c_started: cover property ($rose(startup_done));
    c_held: cover property ($rose(proc_hold));
    c_hpf: cover property ($rose(hpf_init_hold));
endmodule
`default_nettype wire

/* File: dv/hmr_host.sv */
// host serial master model: 12 ns link clock, still between frames
// assumes the core samples mosi on sclk rise and shifts miso on the fall
`timescale 1ns/100ps
`default_nettype none
module hmr_host (
    // link
    output logic sclk,
    output logic load,
    output logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe_n
);
    wire miso_w;
    // a released line shows the opposite level, never a stale one
    assign miso_w = miso_oe_n ? ~miso_o : miso_o;
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        // a rising chip select at start clears the core's link counters
        load = 1'b0;
        #1 load = 1'b1;
    end
    // sends the low nbits of word msb first, returns the first byte seen
    task automatic frame(input logic [15:0] word, input int nbits, output logic [7:0] resp);
        #1 load = 1'b0;
        #10;
        for (int i = nbits - 1; i >= 0; i--) begin
            #1 mosi = word[i];
            #5 sclk = 1'b1;
            if (i >= nbits - 8) resp[i - nbits + 8] = miso_w;
            #6 sclk = 1'b0;
        end
        #20 load = 1'b1;
        mosi = ~mosi;
        #60;
    endtask
endmodule
`default_nettype wire

/* File: dv/tb_health_monitor_and_recovery.sv */
// self-checking bench for the health monitor core with a host link model
// assumes shortened counts: reset hold 8, stretch 20, phase two 50 cycles
`timescale 1ns/100ps
`default_nettype none
module tb_health_monitor_and_recovery;
    import hmr_pkg::*;
    localparam int STR = 20;
    localparam int IN2 = 50;
    localparam int BITS[7] = '{4, 2, 7, 1, 5, 6, 3};
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic sclk, load, mosi, miso_o, miso_oe_n;
    logic hpf_init_hold, hpf_auto_init, proc_hold, startup_done;
    hmr_mon_t mon_i = 7'h7E;
    logic [9:0] rate_sample = 10'h000;
    logic [7:0] health_flags;
    logic [7:0] r;
    int miscompares = 0;
    int compares = 0;
    always #2 sys_clk = ~sys_clk;
    hmr_core #(.RESET_HOLD(8), .STRETCH(STR), .INIT2(IN2)) dut (.sys_clk(sys_clk),
        .reset(reset), .sclk(sclk), .load(load), .mosi(mosi), .miso_o(miso_o),
        .miso_oe_n(miso_oe_n), .mon_i(mon_i), .rate_sample(rate_sample),
        .hpf_init_hold(hpf_init_hold), .hpf_auto_init(hpf_auto_init),
        .proc_hold(proc_hold), .health_flags(health_flags), .startup_done(startup_done));
    hmr_host host (.sclk(sclk), .load(load), .mosi(mosi), .miso_o(miso_o),
        .miso_oe_n(miso_oe_n));
    function automatic logic [7:0] flags_of(input hmr_mon_t m);
        return {m, 1'b1};
    endfunction
    task automatic close_out();
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // r returns the answer to the previous frame
    task automatic cmd(input logic [7:0] a, input logic [7:0] c, input int n = 16);
        @(posedge sys_clk);
        host.frame({a, c}, n, r);
    endtask
    task automatic unlock();
        cmd(ADDR_UNLOCK1, CMD_UNLOCK1);
        cmd(ADDR_UNLOCK2, CMD_UNLOCK2);
        cmd(ADDR_UNLOCK3, CMD_UNLOCK3);
    endtask
    // flags are clear before entry; the guard stays open only a few frames
    task automatic recover();
        unlock();
        cmd(8'h00, CMD_REENABLE, 8);
        cmd(8'h00, CMD_LOCK, 8);
        chk8(r, RESP_RESET);
        cyc(4);
    endtask
    // sample changes after the high read, so the low byte proves the latch
    task automatic rate_chk(input logic sub);
        logic [9:0] s;
        s = 10'($urandom);
        @(posedge sys_clk) rate_sample <= s;
        cmd(8'h00, CMD_RATE_HIGH, 8);
        @(posedge sys_clk) rate_sample <= ~s;
        cmd(8'h00, CMD_RATE_LOW, 8);
        chk8(r, sub ? ERROR_CODE : s[9:2]);
        cmd(8'h00, CMD_FLAG_READ, 8);
        chk8(r, sub ? ERROR_CODE : {LOW_PATTERN, s[1:0]});
    endtask
    task automatic pulse(input int i, input int n);
        @(posedge sys_clk) mon_i[i] <= 1'b0;
        cyc(n);
        mon_i[i] <= 1'b1;
    endtask
    initial begin
        int k;
        logic fat;
        void'($urandom(8));
        fat = 1'b0;
        cyc(3);
        reset <= 1'b0;
        cyc(16);
        chk8(health_flags, flags_of(mon_i));
        rate_chk(1'b1);
        cmd(8'h00, CMD_FLAG_READ, 8);
        cmd(8'h00, CMD_FLAG_READ, 8);
        chk8(r, flags_of(mon_i));
        cmd(8'h00, 8'h3C, 8);
        cmd(8'h00, CMD_FLAG_READ, 8);
        chk8(r, ERROR_CODE);
        cmd(8'h00, CMD_RATE_HIGH, 4);
        cmd(8'h00, CMD_RATE_LOW, 8);
        chk8(r, flags_of(mon_i));
        unlock();
        cmd(8'h01, CMD_HPF_INIT);
        cyc(4);
        chk1(hpf_init_hold, 1'b1);
        cmd(8'h00, CMD_HPF_INIT);
        cyc(4);
        chk1(hpf_init_hold, 1'b0);
        cmd(8'h00, CMD_LOCK, 8);
        cyc(4);
        chk1(proc_hold, 1'b1);
        chk1(startup_done, 1'b0);
        @(posedge sys_clk) mon_i.excitation_locked <= 1'b1;
        k = 0;
        while (startup_done !== 1'b1 && k < 300) begin
            cyc(1);
            k++;
        end
        chk1(k >= IN2, 1'b1);
        chk1(startup_done, 1'b1);
        rate_chk(1'b1);
        recover();
        chk1(proc_hold, 1'b0);
        rate_chk(1'b0);
        cmd(8'h01, CMD_HPF_INIT);
        cyc(4);
        chk1(hpf_init_hold, 1'b0);
        cmd(ADDR_UNLOCK1, CMD_UNLOCK1);
        cmd(ADDR_UNLOCK2 ^ 8'h01, CMD_UNLOCK2);
        cmd(ADDR_UNLOCK3, CMD_UNLOCK3);
        cmd(8'h01, CMD_HPF_INIT);
        cyc(4);
        chk1(hpf_init_hold, 1'b0);
        unlock();
        pulse(6, 2);
        cyc(STR + 10);
        cmd(8'h00, CMD_LOCK, 8);
        cyc(4);
        chk1(proc_hold, 1'b0);
        pulse(1, 1);
        cyc(STR - 4);
        chk1(health_flags[2], 1'b0);
        cyc(14);
        chk1(health_flags[2], 1'b1);
        foreach (BITS[j]) begin
            fat = fat || BITS[j] inside {3, 5, 6};
            @(posedge sys_clk) mon_i[BITS[j] - 1] <= 1'b0;
            cyc(4 + $urandom_range(0, 6));
            chk1(health_flags[BITS[j]], 1'b0);
            rate_chk(BITS[j] != 4 || fat);
            @(posedge sys_clk) mon_i[BITS[j] - 1] <= 1'b1;
            cyc(STR + 10);
            chk1(proc_hold, !(BITS[j] inside {2, 4}) || fat);
            recover();
            chk1(proc_hold, fat);
        end
        close_out();
    end
    initial begin
        #300000;
        miscompares++;
        close_out();
    end
endmodule
bind hmr_core hmr_core_chk #(.STRETCH(STRETCH), .INIT2(INIT2)) u_chk (.sys_clk(sys_clk),
    .reset(reset), .mon_i(mon_i), .health_flags(health_flags),
    .hpf_auto_init(hpf_auto_init), .hpf_init_hold(hpf_init_hold),
    .proc_hold(proc_hold), .startup_done(startup_done));
`default_nettype wire
